// [include/hiem_params.svh]
// Purpose: Offsets, bit positions and reset values for the interrupt mask block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per address
// Notes:   Set/clear address pairs share one storage register
`ifndef HIEM_PARAMS_SVH
`define HIEM_PARAMS_SVH

`define HIEM_OFF_EVT_SET      8'h00
`define HIEM_OFF_EVT_CLR      8'h04
`define HIEM_OFF_MASK_SET     8'h08
`define HIEM_OFF_MASK_CLR     8'h0C
`define HIEM_OFF_TXEVT_SET    8'h10
`define HIEM_OFF_TXEVT_CLR    8'h14
`define HIEM_OFF_TXMASK_SET   8'h18
`define HIEM_OFF_TXMASK_CLR   8'h1C
`define HIEM_OFF_RXEVT_SET    8'h20
`define HIEM_OFF_RXEVT_CLR    8'h24
`define HIEM_OFF_RXMASK_SET   8'h28
`define HIEM_OFF_RXMASK_CLR   8'h2C

`define HIEM_BIT_TX_SUMMARY   6
`define HIEM_BIT_RX_SUMMARY   7
`define HIEM_BIT_NODE_ID_DONE 16
`define HIEM_BIT_BUS_REINIT   17
`define HIEM_BIT_GLOBAL_EN    31

`define HIEM_EVT_USED         32'h07FF03FF
`define HIEM_MASK_USED        32'h87FF03FF
`define HIEM_IRQ_ALWAYS       2'h3
`define HIEM_RESET_ZERO       32'h00000000
`define HIEM_RESP_OKAY        2'h0
`define HIEM_RESP_SLVERR      2'h2

`endif

// [include/hiem_pkg.sv]
// Purpose: Types shared by the interrupt mask block
// Assumes: Constants live in hiem_params.svh
// Notes:   Completion report carries context index and interrupt field
package hiem_pkg;

   typedef struct packed {
      logic       valid;
      logic [4:0] ctx_idx;
      logic [1:0] irq_field;
   } hiem_dma_done_t;

   typedef enum logic [0:0] {
      HIEM_RD_IDLE,
      HIEM_RD_RESP
   } hiem_rd_state_t;

endpackage

// [hw/hiem_top.sv]
// Purpose: Main event/mask aggregation with isochronous summaries, AXI4-Lite slave
// Assumes: Single host clock; event sources are synchronous pulses
// Notes:   Main event bits other than the summaries arrive on evt_set_in
`timescale 1ns/10ps
`include "hiem_params.svh"

module hiem_top
   import hiem_pkg::*;
#(
   parameter logic [31:0] TX_CTX_IMPL = 32'h0000000F,
   parameter logic [31:0] RX_CTX_IMPL = 32'h0000000F
) (
   // Clock and reset
   input  wire logic           aclk,
   input  wire logic           aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]     s_axi_awaddr,
   input  wire logic           s_axi_awvalid,
   output logic                s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]    s_axi_wdata,
   input  wire logic [3:0]     s_axi_wstrb,
   input  wire logic           s_axi_wvalid,
   output logic                s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]          s_axi_bresp,
   output logic                s_axi_bvalid,
   input  wire logic           s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]     s_axi_araddr,
   input  wire logic           s_axi_arvalid,
   output logic                s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]         s_axi_rdata,
   output logic [1:0]          s_axi_rresp,
   output logic                s_axi_rvalid,
   input  wire logic           s_axi_rready,
   // Event sources
   input  wire logic [31:0]    evt_set_in,
   input  wire logic           bus_reinit_in,
   input  wire logic           node_id_phase_in,
   input  hiem_dma_done_t      tx_done_in,
   input  hiem_dma_done_t      rx_done_in,
   // Processor interrupt
   output logic                irq_out
);

   // Register state
   logic [31:0] main_event_register_ff;
   logic [31:0] master_interrupt_mask_ff;
   logic [31:0] iso_transmit_event_ff;
   logic [31:0] iso_transmit_mask_ff;
   logic [31:0] iso_receive_event_ff;
   logic [31:0] iso_receive_mask_ff;

   // Bus channel state
   logic [7:0]     awaddr_ff;
   logic           aw_held_ff;
   logic [31:0]    wdata_ff;
   logic [3:0]     wstrb_ff;
   logic           w_held_ff;
   hiem_rd_state_t rd_state_ff;

   logic [31:0] tx_pulse;
   logic [31:0] rx_pulse;
   logic [31:0] main_view;
   logic [31:0] wmask;
   logic        wr_fire;
   logic        bus_reinit_clr_req;

   // Apply byte strobes to a data word
   function automatic logic [31:0] strobe_bits(input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Apply a set/clear write pair; sets come after clears so an event wins
   function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] setb,
                                           input logic [31:0] clrb);
      return (cur & ~clrb) | setb;
   endfunction

   // One-hot pulse when a completion carries interrupt-always
   function automatic logic [31:0] done_pulse(input hiem_dma_done_t d);
      logic [31:0] r;
      r = 32'h00000000;
      if (d.valid && d.irq_field == `HIEM_IRQ_ALWAYS) begin
         r[d.ctx_idx] = 1'b1;
      end
      return r;
   endfunction

   assign tx_pulse = done_pulse(tx_done_in);
   assign rx_pulse = done_pulse(rx_done_in);

   always_comb begin
      main_view = main_event_register_ff;
      main_view[`HIEM_BIT_TX_SUMMARY] = |(iso_transmit_event_ff & iso_transmit_mask_ff);
      main_view[`HIEM_BIT_RX_SUMMARY] = |(iso_receive_event_ff & iso_receive_mask_ff);
   end

   // Write path: address and data taken in either order
   assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
   assign wmask   = strobe_bits(wdata_ff, wstrb_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff    <= 1'b0;
         awaddr_ff     <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_held_ff    <= 1'b0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff    <= 1'b1;
         awaddr_ff     <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_ff && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff    <= 1'b0;
         wdata_ff     <= 32'h00000000;
         wstrb_ff     <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_held_ff    <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff    <= 1'b1;
         wdata_ff     <= s_axi_wdata;
         wstrb_ff     <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_ff && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `HIEM_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_ff[1:0] == 2'h0 && awaddr_ff <= `HIEM_OFF_RXMASK_CLR) ?
                         `HIEM_RESP_OKAY : `HIEM_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Decode write strobes per set/clear address
   function automatic logic [31:0] wr_hit(input logic [7:0] off);
      return (wr_fire && awaddr_ff == off) ? wmask : 32'h00000000;
   endfunction

   // clear of bus reinit dropped during identification phase
   assign bus_reinit_clr_req = !node_id_phase_in;

   // Main event register; summary bits 6 and 7 are stored here but main_view replaces them
   always_ff @(posedge aclk) begin
      logic [31:0] clrb;
      logic [31:0] nxt_evt;
      clrb = wr_hit(`HIEM_OFF_EVT_CLR);
      if (!bus_reinit_clr_req) begin
         clrb[`HIEM_BIT_BUS_REINIT] = 1'b0;
      end
      nxt_evt = set_clr(main_event_register_ff, wr_hit(`HIEM_OFF_EVT_SET) | evt_set_in, clrb);
      // bus reinit sets bit 17 and clears bit 16
      if (bus_reinit_in) begin
         nxt_evt[`HIEM_BIT_BUS_REINIT]   = 1'b1;
         nxt_evt[`HIEM_BIT_NODE_ID_DONE] = 1'b0;
      end
      if (!aresetn) begin
         main_event_register_ff <= `HIEM_RESET_ZERO;
      end else begin
         main_event_register_ff <= nxt_evt & `HIEM_EVT_USED;
      end
   end

   // master mask, global enable cleared by reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         master_interrupt_mask_ff <= `HIEM_RESET_ZERO;
      end else begin
         master_interrupt_mask_ff <= set_clr(master_interrupt_mask_ff,
                                             wr_hit(`HIEM_OFF_MASK_SET),
                                             wr_hit(`HIEM_OFF_MASK_CLR)) & `HIEM_MASK_USED;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         iso_transmit_event_ff <= `HIEM_RESET_ZERO;
      end else begin
         iso_transmit_event_ff <= set_clr(iso_transmit_event_ff,
                                          wr_hit(`HIEM_OFF_TXEVT_SET) | tx_pulse,
                                          wr_hit(`HIEM_OFF_TXEVT_CLR)) & TX_CTX_IMPL;
      end
   end

   // transmit mask, unimplemented contexts stay zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         iso_transmit_mask_ff <= `HIEM_RESET_ZERO;
      end else begin
         iso_transmit_mask_ff <= set_clr(iso_transmit_mask_ff, wr_hit(`HIEM_OFF_TXMASK_SET),
                                         wr_hit(`HIEM_OFF_TXMASK_CLR)) & TX_CTX_IMPL;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         iso_receive_event_ff <= `HIEM_RESET_ZERO;
      end else begin
         iso_receive_event_ff <= set_clr(iso_receive_event_ff,
                                         wr_hit(`HIEM_OFF_RXEVT_SET) | rx_pulse,
                                         wr_hit(`HIEM_OFF_RXEVT_CLR)) & RX_CTX_IMPL;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         iso_receive_mask_ff <= `HIEM_RESET_ZERO;
      end else begin
         iso_receive_mask_ff <= set_clr(iso_receive_mask_ff, wr_hit(`HIEM_OFF_RXMASK_SET),
                                        wr_hit(`HIEM_OFF_RXMASK_CLR)) & RX_CTX_IMPL;
      end
   end

   // Read path, one request at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_ff   <= HIEM_RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `HIEM_RESP_OKAY;
      end else begin
         case (rd_state_ff)
            HIEM_RD_IDLE: begin
               s_axi_arready <= 1'b1;
               if (s_axi_arvalid && s_axi_arready) begin
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rresp   <= `HIEM_RESP_OKAY;
                  rd_state_ff   <= HIEM_RD_RESP;
                  case (s_axi_araddr)
                     `HIEM_OFF_EVT_SET:    s_axi_rdata <= main_view;
                     `HIEM_OFF_EVT_CLR:    s_axi_rdata <= main_view & master_interrupt_mask_ff;
                     `HIEM_OFF_MASK_SET,
                     `HIEM_OFF_MASK_CLR:   s_axi_rdata <= master_interrupt_mask_ff;
                     `HIEM_OFF_TXEVT_SET:  s_axi_rdata <= iso_transmit_event_ff;
                     `HIEM_OFF_TXEVT_CLR:  s_axi_rdata <= iso_transmit_event_ff &
                                                          iso_transmit_mask_ff;
                     `HIEM_OFF_TXMASK_SET,
                     `HIEM_OFF_TXMASK_CLR: s_axi_rdata <= iso_transmit_mask_ff;
                     `HIEM_OFF_RXEVT_SET:  s_axi_rdata <= iso_receive_event_ff;
                     `HIEM_OFF_RXEVT_CLR:  s_axi_rdata <= iso_receive_event_ff &
                                                          iso_receive_mask_ff;
                     `HIEM_OFF_RXMASK_SET,
                     `HIEM_OFF_RXMASK_CLR: s_axi_rdata <= iso_receive_mask_ff;
                     default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `HIEM_RESP_SLVERR;
                     end
                  endcase
               end
            end
            HIEM_RD_RESP: begin
               s_axi_arready <= 1'b0;
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_state_ff  <= HIEM_RD_IDLE;
               end
            end
            default: begin
               rd_state_ff <= HIEM_RD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= master_interrupt_mask_ff[`HIEM_BIT_GLOBAL_EN] &&
                    |(main_view & master_interrupt_mask_ff & `HIEM_EVT_USED);
      end
   end

endmodule

// [sim/hiem_chk_assertions.sv]
// Purpose: Port-level checks for hiem_top
// Assumes: One clock, synchronous active-low reset
// Notes:   Register state is seen only through bus reads and irq_out
`timescale 1ns/10ps
`include "hiem_params.svh"
module hiem_chk
   import hiem_pkg::*;
(
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Write channels
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Read channels
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Events and interrupt
   input wire logic [31:0] evt_set_in,
   input wire logic        bus_reinit_in,
   input wire logic        node_id_phase_in,
   input hiem_dma_done_t   tx_done_in,
   input hiem_dma_done_t   rx_done_in,
   input wire logic        irq_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Unmapped or unaligned places answer with an error
   wire bad_aw = (s_axi_awaddr > 8'h2C) || (s_axi_awaddr[1:0] != 2'h0);
   wire bad_ar = (s_axi_araddr > 8'h2C) || (s_axi_araddr[1:0] != 2'h0);
   wire hw_evt = (evt_set_in != 32'h0) || bus_reinit_in || tx_done_in.valid || rx_done_in.valid;
   property p_rst_irq; $rose(aresetn) |-> !irq_out; endproperty
   a_rst_irq: assert property (p_rst_irq) else $error("irq high after reset");
   property p_b_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid
         && s_axi_bresp == ($past(bad_aw, 2) ? `HIEM_RESP_SLVERR : `HIEM_RESP_OKAY);
   endproperty
   a_b_ans: assert property (p_b_ans) else $error("write answer wrong");
   property p_r_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && (!$past(bad_ar)
         || (s_axi_rdata == 32'h0 && s_axi_rresp == `HIEM_RESP_SLVERR));
   endproperty
   a_r_ans: assert property (p_r_ans) else $error("read answer wrong");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_w_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_w_refuse: assert property (p_w_refuse) else $error("write taken during response");
   property p_r_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r_refuse: assert property (p_r_refuse) else $error("read taken during response");
   // Irq only moves after a register write or an event input
   property p_irq_rise; $rose(irq_out) |-> $past(s_axi_bvalid) || $past(hw_evt, 2); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
   property p_irq_fall; $fell(irq_out) |-> $past(s_axi_bvalid) || $past(bus_reinit_in, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
   c_irq: cover property ($rose(irq_out));
   c_rerr: cover property (s_axi_rvalid && s_axi_rresp == `HIEM_RESP_SLVERR);
   c_reinit: cover property (bus_reinit_in && node_id_phase_in);
endmodule
bind hiem_top hiem_chk chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .evt_set_in(evt_set_in), .bus_reinit_in(bus_reinit_in),
   .node_id_phase_in(node_id_phase_in), .tx_done_in(tx_done_in), .rx_done_in(rx_done_in),
   .irq_out(irq_out));

// [sim/tb_top.sv]
// Purpose: Self-checking bench for hiem_top against a register model
// Assumes: Bus and event timing as handed over by the designer
// Notes:   Sparse context sets expose stuck mask bits
`timescale 1ns/10ps
`include "hiem_params.svh"
module tb_top import hiem_pkg::*; ;
   localparam logic [31:0] TXI = 32'h000000A5;
   localparam logic [31:0] RXI = 32'h0000F00F;
   localparam logic [31:0] EVS = `HIEM_EVT_USED & 32'hFFFFFF3F;
   logic           aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic           arvalid = 1'b0, rready = 1'b0, reinit = 1'b0, phase = 1'b0;
   logic [7:0]     awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]    wdata = 32'h0, evt_in = 32'h0, rdata, v;
   logic [1:0]     bresp, rresp;
   logic           awready, wready, bvalid, arready, rvalid, irq;
   hiem_dma_done_t tx_d = '0, rx_d = '0;
   logic [31:0]    m_evt = 32'h0, m_msk = 32'h0, m_txe = 32'h0, m_txm = 32'h0;
   logic [31:0]    m_rxe = 32'h0, m_rxm = 32'h0;
   int             bad_count = 0, comparisons = 0;
   always #2 aclk = ~aclk;
   hiem_top #(.TX_CTX_IMPL(TXI), .RX_CTX_IMPL(RXI)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .evt_set_in(evt_in), .bus_reinit_in(reinit), .node_id_phase_in(phase),
      .tx_done_in(tx_d), .rx_done_in(rx_d), .irq_out(irq));
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tmo();
      bad_count++;
      $display("[FAIL] %0t bus wait ran out", $time);
      finish_test();
   endtask
   // Summaries are live, never stored
   function automatic logic [31:0] full_evt();
      return m_evt | {24'h0, |(m_rxe & m_rxm), |(m_txe & m_txm), 6'h00};
   endfunction
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h00: return full_evt();
         8'h04: return full_evt() & m_msk;
         8'h08, 8'h0C: return m_msk;
         8'h10: return m_txe;
         8'h14: return m_txe & m_txm;
         8'h18, 8'h1C: return m_txm;
         8'h20: return m_rxe;
         8'h24: return m_rxe & m_rxm;
         8'h28, 8'h2C: return m_rxm;
         default: return 32'h0;
      endcase
   endfunction
   task automatic mdl_wr(input logic [7:0] a, input logic [31:0] d);
      case (a)
         8'h00: m_evt |= d & EVS;
         8'h04: m_evt &= ~(d & ~{14'h0, phase, 17'h0});
         8'h08: m_msk |= d & `HIEM_MASK_USED;
         8'h0C: m_msk &= ~d;
         8'h10: m_txe |= d & TXI;
         8'h14: m_txe &= ~d;
         8'h18: m_txm |= d & TXI;
         8'h1C: m_txm &= ~d;
         8'h20: m_rxe |= d & RXI;
         8'h24: m_rxe &= ~d;
         8'h28: m_rxm |= d & RXI;
         8'h2C: m_rxm &= ~d;
         default: ;
      endcase
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw;
      n = 0;
      ta = 1'b0;
      tw = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ta && tw) && n < 40) begin
         @(posedge aclk);
         n++;
         if (awready && !ta) begin
            awvalid <= 1'b0;
            ta = 1'b1;
         end
         if (wready && !tw) begin
            wvalid <= 1'b0;
            tw = 1'b1;
         end
      end
      do begin
         @(posedge aclk);
         n++;
      end while (!bvalid && n < 80);
      bready <= 1'b0;
      if (n >= 80) tmo();
      mdl_wr(a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!arready && n < 40);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (!rvalid && n < 80);
      rready <= 1'b0;
      if (n >= 80) tmo();
      check(rdata, exp_rd(a));
      check({31'h0, irq}, {31'h0, m_msk[31] && |(full_evt() & m_msk & 32'h7FFFFFFF)});
   endtask
   task automatic dma(input logic rx, input logic [4:0] c, input logic [1:0] f);
      if (rx) rx_d <= {1'b1, c, f};
      else tx_d <= {1'b1, c, f};
      @(posedge aclk);
      rx_d <= '0;
      tx_d <= '0;
      @(posedge aclk);
      if (f == 2'h3 && rx) m_rxe |= RXI & (32'h1 << c);
      if (f == 2'h3 && !rx) m_txe |= TXI & (32'h1 << c);
   endtask
   task automatic hw(input logic [31:0] e, input logic r);
      evt_in <= e;
      reinit <= r;
      @(posedge aclk);
      evt_in <= 32'h0;
      reinit <= 1'b0;
      @(posedge aclk);
      m_evt |= e & EVS;
      if (r) m_evt = (m_evt | 32'h00020000) & 32'hFFFEFFFF;
   endtask
   initial begin
      void'($urandom(16606));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 0; a <= 8'h2C; a += 4) rd(a[7:0]);
      wr(8'h18, 32'hFFFFFFFF);
      wr(8'h28, 32'hFFFFFFFF);
      rd(8'h18);
      rd(8'h2C);
      for (int f = 0; f < 4; f++) dma(1'b0, 5'd5, f[1:0]);
      for (int f = 0; f < 4; f++) dma(1'b1, 5'd3, f[1:0]);
      dma(1'b0, 5'd1, 2'h3);
      rd(8'h10);
      rd(8'h24);
      rd(8'h00);
      wr(8'h1C, 32'h00000020);
      rd(8'h00);
      repeat (4) begin
         v = $urandom;
         wr(8'h20, v);
         rd(8'h20);
         wr(8'h24, $urandom);
         rd(8'h00);
      end
      hw(32'h00010000, 1'b0);
      hw(32'h0, 1'b1);
      rd(8'h00);
      phase <= 1'b1;
      wr(8'h04, 32'h00030000);
      rd(8'h00);
      phase <= 1'b0;
      wr(8'h08, 32'h00020000);
      rd(8'h04);
      wr(8'h08, 32'h80000000);
      rd(8'h04);
      wr(8'h0C, 32'h00020000);
      rd(8'h08);
      wr(8'h08, 32'h00020000);
      wr(8'h04, 32'h00020000);
      rd(8'h00);
      hw($urandom & 32'h0000033F, 1'b0);
      rd(8'h04);
      wr(8'h40, 32'hFFFFFFFF);
      rd(8'h40);
      finish_test();
   end
endmodule
